/* hdl/tcc_map.vh */
// register offsets, field positions, reset values and codes of the timer capture/compare channel
`ifndef TCC_MAP_VH
`define TCC_MAP_VH

// register offsets on the register port
`define TCC_OFS_MODE 4'h2
`define TCC_OFS_FFCR 4'h3
`define TCC_OFS_STAT 4'h4

// mode register fields
`define TCC_MODE_CLK_LSB 0
`define TCC_MODE_CLK_MSB 1
`define TCC_MODE_CLE_BIT 2
`define TCC_MODE_CPM_LSB 3
`define TCC_MODE_CPM_MSB 4
`define TCC_MODE_SWCAP_BIT 5
`define TCC_MODE_RESET 8'h20

// flip-flop control register fields
`define TCC_FFCR_CTL_LSB 0
`define TCC_FFCR_CTL_MSB 1
`define TCC_FFCR_E0_BIT 2
`define TCC_FFCR_E1_BIT 3
`define TCC_FFCR_C0_BIT 4
`define TCC_FFCR_C1_BIT 5
`define TCC_FFCR_RESET 8'h03

// status register fields
`define TCC_STAT_M0_BIT 0
`define TCC_STAT_M1_BIT 1
`define TCC_STAT_OVF_BIT 2

// count clock select codes
`define TCC_CLK_PIN0 2'h0
`define TCC_CLK_DIV1 2'h1
`define TCC_CLK_DIV4 2'h2
`define TCC_CLK_DIV16 2'h3

// capture timing codes
`define TCC_CPM_OFF 2'h0
`define TCC_CPM_PINS 2'h1
`define TCC_CPM_PIN0 2'h2
`define TCC_CPM_TRIG 2'h3

// flip-flop software control codes
`define TCC_FF_INVERT 2'h0
`define TCC_FF_SET 2'h1
`define TCC_FF_CLEAR 2'h2
`define TCC_FF_KEEP 2'h3

// prescaler tap positions and last channel that listens to channel 9
`define TCC_PRE_DIV4_LAST 4'h3
`define TCC_PRE_DIV16_LAST 4'hf
`define TCC_TRIG_CH9_LAST 4

`endif

/* hdl/tcc_chan.v */
// one 16-bit timer/event counter channel with compare, capture and timer flip-flop
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ns
//
// Overview of operation
// - clock select 00 pin0, 01 div1, 10 div4, 11 div16 drives counting
// - clear-on-match bit 1 clears counter at compare1 match; 0 never clears
// - capture code 00 off; 01 pin0 rise to capture0, pin1 rise to capture1
// - code 10: pin0 rise to capture0, pin0 fall to capture1
// - code 11: trigger rise to capture0, trigger fall to capture1
// - channels 0..4 use channel 9 output as trigger, 5..A use channel 3
// - writing 0 to software capture bit latches count into capture0; 1 ignored
// - mode bit 5 always reads 1, reset value shows it as 1
// - flip-flop control write: 00 invert, 01 set, 10 clear, 11 keep
// - flip-flop control field always reads back 11
// - enabled compare0/compare1 matches each toggle the timer flip-flop
// - enabled captures into capture0/capture1 each toggle the timer flip-flop
// - compare0 match sets its status flag and signals interrupt
// - compare1 match sets its own status flag and signals interrupt
// - counter overflow sets a third status flag and signals interrupt
// - each event sets its flag and notifies; status read clears all flags
// - 16-bit compare against both compare registers, interrupt on any match
// - timer flip-flop drives the channel timer output
`include "tcc_map.vh"

module tcc_chan #(
	parameter CHANNEL = 0,
	parameter CNT_W = 16
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// register port
	input wire [3:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output wire [7:0] reg_rdata_o,
	// run controls and compare values held elsewhere
	input wire counter_run_i,
	input wire prescaler_run_i,
	input wire [CNT_W-1:0] compare_register0_i,
	input wire [CNT_W-1:0] compare_register1_i,
	// capture and trigger inputs
	input wire capture_input_pin0_i,
	input wire capture_input_pin1_i,
	input wire channel9_timer_output_i,
	input wire channel3_timer_output_i,
	// results
	output wire [CNT_W-1:0] counter_o,
	output wire [CNT_W-1:0] capture_register0_o,
	output wire [CNT_W-1:0] capture_register1_o,
	output wire timer_output_o,
	output wire irq_o
);

	// configuration held in registers
	reg [1:0] count_clock_select_reg;
	reg counter_clear_on_match1_reg;
	reg [1:0] capture_timing_select_reg;
	reg [1:0] toggle_on_compare_enable_reg;
	reg [1:0] toggle_on_capture_enable_reg;

	// datapath state
	reg [3:0] prescale_reg;
	reg [CNT_W-1:0] count_reg;
	reg [CNT_W-1:0] count_next;
	reg [CNT_W-1:0] cap0_reg;
	reg [CNT_W-1:0] cap1_reg;
	reg timer_output_flipflop_reg;
	reg timer_output_flipflop_next;
	reg [2:0] status_reg;
	reg [2:0] status_next;
	reg irq_reg;
	reg [7:0] rdata_reg;
	reg [7:0] rdata_next;

	// previous samples for edge detection: pin0, pin1, internal trigger
	reg [2:0] edge_prev_reg;
	wire [2:0] edge_in;

	// decoded events
	wire internal_capture_trigger;
	wire wr_mode;
	wire wr_ffcr;
	wire rd_stat;
	wire pin0_rise;
	wire pin0_fall;
	wire pin1_rise;
	wire trig_rise;
	wire trig_fall;
	reg count_tick;
	reg hw_cap0;
	reg hw_cap1;
	wire sw_cap0;
	wire cap0_evt;
	wire cap1_evt;
	wire match0_evt;
	wire match1_evt;
	wire ovf_evt;
	wire ff_toggle;
	wire [2:0] event_vec;

	assign internal_capture_trigger = (CHANNEL <= `TCC_TRIG_CH9_LAST) ?
		channel9_timer_output_i : channel3_timer_output_i;

	assign wr_mode = reg_wr_i && (reg_addr_i == `TCC_OFS_MODE);
	assign wr_ffcr = reg_wr_i && (reg_addr_i == `TCC_OFS_FFCR);
	assign rd_stat = reg_rd_i && (reg_addr_i == `TCC_OFS_STAT);

	// inputs are synchronous, so one stored sample per input is enough for edges
	assign edge_in = {internal_capture_trigger, capture_input_pin1_i, capture_input_pin0_i};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_edge
			always @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					edge_prev_reg[gi] <= 1'b0;
				end else begin
					edge_prev_reg[gi] <= edge_in[gi];
				end
			end
		end
	endgenerate

	assign pin0_rise = edge_in[0] && !edge_prev_reg[0];
	assign pin0_fall = !edge_in[0] && edge_prev_reg[0];
	assign pin1_rise = edge_in[1] && !edge_prev_reg[1];
	assign trig_rise = edge_in[2] && !edge_prev_reg[2];
	assign trig_fall = !edge_in[2] && edge_prev_reg[2];

	// prescaler taps; stopping it clears the prescaler so a restart begins a full period
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prescale_reg <= 4'h0;
		end else if (prescaler_run_i) begin
			prescale_reg <= prescale_reg + 4'h1;
		end else begin
			prescale_reg <= 4'h0;
		end
	end

	// count tick selection
	always @* begin
		count_tick = 1'b0;
		case (count_clock_select_reg)
			`TCC_CLK_PIN0: count_tick = pin0_rise;
			`TCC_CLK_DIV1: count_tick = prescaler_run_i;
			`TCC_CLK_DIV4: count_tick = prescaler_run_i &&
				(prescale_reg[1:0] == `TCC_PRE_DIV4_LAST);
			`TCC_CLK_DIV16: count_tick = prescaler_run_i &&
				(prescale_reg == `TCC_PRE_DIV16_LAST);
			default: count_tick = 1'b0;
		endcase
	end

	// up-counter: the value after a compare1 match is zero when clearing is enabled
	always @* begin
		count_next = count_reg;
		if (!counter_run_i) begin
			count_next = {CNT_W{1'b0}};
		end else if (count_tick) begin
			if (counter_clear_on_match1_reg && (count_reg == compare_register1_i)) begin
				count_next = {CNT_W{1'b0}};
			end else begin
				count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// matches are raised on the tick that brings the counter onto the value
	assign match0_evt = counter_run_i && count_tick && (count_next == compare_register0_i);
	assign match1_evt = counter_run_i && count_tick && (count_next == compare_register1_i);
	assign ovf_evt = counter_run_i && count_tick && (&count_reg) &&
		!(counter_clear_on_match1_reg && (count_reg == compare_register1_i));

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_reg <= {CNT_W{1'b0}};
		end else begin
			count_reg <= count_next;
		end
	end

	// hardware capture selection
	always @* begin
		hw_cap0 = 1'b0;
		hw_cap1 = 1'b0;
		case (capture_timing_select_reg)
			`TCC_CPM_OFF: begin
				hw_cap0 = 1'b0;
				hw_cap1 = 1'b0;
			end
			`TCC_CPM_PINS: begin
				hw_cap0 = pin0_rise;
				hw_cap1 = pin1_rise;
			end
			`TCC_CPM_PIN0: begin
				hw_cap0 = pin0_rise;
				hw_cap1 = pin0_fall;
			end
			`TCC_CPM_TRIG: begin
				hw_cap0 = trig_rise;
				hw_cap1 = trig_fall;
			end
			default: begin
				hw_cap0 = 1'b0;
				hw_cap1 = 1'b0;
			end
		endcase
	end

	// software capture acts only on a written 0, whether or not the prescaler is running
	assign sw_cap0 = wr_mode && !reg_wdata_i[`TCC_MODE_SWCAP_BIT];
	assign cap0_evt = hw_cap0 || sw_cap0;
	assign cap1_evt = hw_cap1;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cap0_reg <= {CNT_W{1'b0}};
			cap1_reg <= {CNT_W{1'b0}};
		end else begin
			if (cap0_evt) begin
				cap0_reg <= count_reg;
			end
			if (cap1_evt) begin
				cap1_reg <= count_reg;
			end
		end
	end

	// several simultaneous enabled events cancel in pairs, as separate toggles would
	assign ff_toggle = (match0_evt && toggle_on_compare_enable_reg[0]) ^
		(match1_evt && toggle_on_compare_enable_reg[1]) ^
		(cap0_evt && toggle_on_capture_enable_reg[0]) ^
		(cap1_evt && toggle_on_capture_enable_reg[1]);

	// a software invert, set or clear wins over hardware toggles in the same cycle; keep lets them through
	always @* begin
		timer_output_flipflop_next = timer_output_flipflop_reg ^ ff_toggle;
		if (wr_ffcr) begin
			case (reg_wdata_i[`TCC_FFCR_CTL_MSB:`TCC_FFCR_CTL_LSB])
				`TCC_FF_INVERT: timer_output_flipflop_next = !timer_output_flipflop_reg;
				`TCC_FF_SET: timer_output_flipflop_next = 1'b1;
				`TCC_FF_CLEAR: timer_output_flipflop_next = 1'b0;
				default: timer_output_flipflop_next = timer_output_flipflop_reg ^ ff_toggle;
			endcase
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			timer_output_flipflop_reg <= 1'b0;
		end else begin
			timer_output_flipflop_reg <= timer_output_flipflop_next;
		end
	end

	localparam [7:0] mode_rst = `TCC_MODE_RESET;

	// configuration writes
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_clock_select_reg <= mode_rst[`TCC_MODE_CLK_MSB:`TCC_MODE_CLK_LSB];
			counter_clear_on_match1_reg <= mode_rst[`TCC_MODE_CLE_BIT];
			capture_timing_select_reg <= mode_rst[`TCC_MODE_CPM_MSB:`TCC_MODE_CPM_LSB];
			toggle_on_compare_enable_reg <= 2'h0;
			toggle_on_capture_enable_reg <= 2'h0;
		end else begin
			if (wr_mode) begin
				count_clock_select_reg <= reg_wdata_i[`TCC_MODE_CLK_MSB:`TCC_MODE_CLK_LSB];
				counter_clear_on_match1_reg <= reg_wdata_i[`TCC_MODE_CLE_BIT];
				capture_timing_select_reg <= reg_wdata_i[`TCC_MODE_CPM_MSB:`TCC_MODE_CPM_LSB];
			end
			if (wr_ffcr) begin
				toggle_on_compare_enable_reg <= {reg_wdata_i[`TCC_FFCR_E1_BIT],
					reg_wdata_i[`TCC_FFCR_E0_BIT]};
				toggle_on_capture_enable_reg <= {reg_wdata_i[`TCC_FFCR_C1_BIT],
					reg_wdata_i[`TCC_FFCR_C0_BIT]};
			end
		end
	end

	// status flags: an event in the reading cycle survives the clear
	assign event_vec = {ovf_evt, match1_evt, match0_evt};

	always @* begin
		status_next = status_reg;
		if (rd_stat) begin
			status_next = 3'h0;
		end
		status_next = status_next | event_vec;
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			status_reg <= 3'h0;
			irq_reg <= 1'b0;
		end else begin
			status_reg <= status_next;
			irq_reg <= |event_vec;
		end
	end

	// read data, valid the cycle after the strobe only
	always @* begin
		rdata_next = 8'h00;
		if (reg_rd_i) begin
			case (reg_addr_i)
				`TCC_OFS_MODE: begin
					rdata_next = {2'h0, 1'b1, capture_timing_select_reg,
						counter_clear_on_match1_reg, count_clock_select_reg};
				end
				`TCC_OFS_FFCR: begin
					rdata_next = {2'h0, toggle_on_capture_enable_reg,
						toggle_on_compare_enable_reg, `TCC_FF_KEEP};
				end
				`TCC_OFS_STAT: begin
					rdata_next = {5'h00, status_reg};
				end
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign counter_o = count_reg;
	assign capture_register0_o = cap0_reg;
	assign capture_register1_o = cap1_reg;
	assign timer_output_o = timer_output_flipflop_reg;
	assign irq_o = irq_reg;

endmodule

/* bench/tcc_chan_sva.sv */
// port-level assertions for the timer capture/compare channel
`timescale 1ns/1ns
module tcc_chan_sva #(
	parameter CNT_W = 16
) (
	input wire clk_i, rst_i, reg_wr_i, reg_rd_i, counter_run_i, timer_output_o, irq_o,
	input wire [3:0] reg_addr_i,
	input wire [7:0] reg_wdata_i, reg_rdata_o,
	input wire [CNT_W-1:0] compare_register0_i, counter_o, capture_register0_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
wire ff_wr = reg_wr_i && reg_addr_i == 4'h3;
wire [CNT_W-1:0] all_ones = {CNT_W{1'b1}};
a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
	else $error("read data not zero outside a read");
a_mode_read: assert property (reg_rd_i && reg_addr_i == 4'h2 |=> reg_rdata_o[7:5] == 3'h1)
	else $error("mode bit 5 not read as one");
a_ctl_read: assert property (reg_rd_i && reg_addr_i == 4'h3 |=> reg_rdata_o[1:0] == 2'h3)
	else $error("flip-flop control not read as 11");
a_ff_set: assert property (ff_wr && reg_wdata_i[1:0] == 2'h1 |=> timer_output_o)
	else $error("timer output not set");
a_ff_clear: assert property (ff_wr && reg_wdata_i[1:0] == 2'h2 |=> !timer_output_o)
	else $error("timer output not cleared");
a_ff_invert: assert property (ff_wr && reg_wdata_i[1:0] == 2'h0 |=> $changed(timer_output_o))
	else $error("timer output not inverted");
a_run_off: assert property (!counter_run_i |=> counter_o == 0 && !irq_o)
	else $error("stopped counter moved or raised an event");
a_count_step: assert property (counter_run_i |=> counter_o == 0 ||
	counter_o == $past(counter_o) || counter_o == $past(counter_o) + 1'b1)
	else $error("counter stepped by more than one");
a_sw_capture: assert property (reg_wr_i && reg_addr_i == 4'h2 && !reg_wdata_i[5]
	|=> capture_register0_o == $past(counter_o))
	else $error("software capture missed the count");
a_match0_irq: assert property (counter_run_i && $changed(counter_o) &&
	compare_register0_i != 0 && counter_o == compare_register0_i |-> irq_o)
	else $error("no event on compare 0 match");
a_ovf_irq: assert property (counter_run_i && $past(counter_o) == all_ones && counter_o == 0
	|-> irq_o)
	else $error("no event on overflow");
endmodule

bind tcc_chan tcc_chan_sva #(.CNT_W(CNT_W)) i_sva (.clk_i(clk_i), .rst_i(rst_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .counter_run_i(counter_run_i),
	.timer_output_o(timer_output_o), .irq_o(irq_o), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.compare_register0_i(compare_register0_i), .counter_o(counter_o),
	.capture_register0_o(capture_register0_o));

/* bench/tb.sv */
// self-checking bench for the timer capture/compare channel
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
$display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
reg clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, counter_run_i = 0, ff = 0, pre = 1;
reg [3:0] reg_addr_i = 0, ins = 0;
reg [7:0] reg_wdata_i = 0, rd;
reg [15:0] cmp0 = 1, cmp1 = 9, exp0 = 0, exp1 = 0, mx;
wire [7:0] reg_rdata_o;
wire [15:0] cnt, cap0, cap1;
wire tout, irq;
integer n_errors = 0, samples_checked = 0, cycles = 0, k, s, e, t;
tcc_chan #(.CHANNEL(0)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .counter_run_i(counter_run_i), .prescaler_run_i(pre),
	.compare_register0_i(cmp0), .compare_register1_i(cmp1), .capture_input_pin0_i(ins[0]),
	.capture_input_pin1_i(ins[1]), .channel9_timer_output_i(ins[2]),
	.channel3_timer_output_i(ins[3]), .counter_o(cnt), .capture_register0_o(cap0),
	.capture_register1_o(cap1), .timer_output_o(tout), .irq_o(irq));
initial forever #20 clk_i = ~clk_i;
task stop_test;
	$display("checks %0d mismatches %0d", samples_checked, n_errors);
	if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
	else $display("Simulation failed");
	$finish;
endtask
// mx keeps the count seen by the edge that takes the write
task wr(input [3:0] a, input [7:0] d);
	@(posedge clk_i);
	reg_addr_i <= a;
	reg_wdata_i <= d;
	reg_wr_i <= 1;
	#1 mx = cnt;
	@(posedge clk_i);
	reg_wr_i <= 0;
	#1;
endtask
task rdc(input [3:0] a, input [7:0] x);
	@(posedge clk_i);
	reg_addr_i <= a;
	reg_rd_i <= 1;
	@(posedge clk_i);
	reg_rd_i <= 0;
	#1 rd = reg_rdata_o;
	`CHK("rdata", x, rd)
endtask
task run(input v);
	@(posedge clk_i);
	counter_run_i <= v;
endtask
// toggles one input; the edge is seen one clock later, so mx is the count it latches
task hit(input integer v);
	@(posedge clk_i);
	ins[v] <= !ins[v];
	#1 mx = cnt;
	repeat (2) @(posedge clk_i);
	#1;
endtask
// which capture register an edge loads: 0, 1, or 2 for none
function integer tgt(input integer c, input integer v, input r);
	if (c == 1 && v < 2 && r) tgt = v;
	else if ((c == 2 && v == 0) || (c == 3 && v == 2)) tgt = !r;
	else tgt = 2;
endfunction
always @(posedge clk_i) begin
	cycles++;
	if (cycles > 90000) begin
		n_errors++;
		stop_test;
	end
end
initial begin
	k = $urandom(32'h72d2);
	repeat (4) @(posedge clk_i);
	rst_i <= 0;
	rdc(4'h2, 8'h20);
	rdc(4'h3, 8'h03);
	rdc(4'h4, 8'h00);
	rdc(4'h9, 8'h00);
	for (k = 0; k < 8; k++) begin
		s = (k + k / 4) % 4;
		wr(4'h3, 8'(s));
		ff = s == 0 ? !ff : s == 1 ? 1'b1 : s == 2 ? 1'b0 : ff;
		`CHK("tout", ff, tout)
	end
	$display("flip-flop control test done");
	for (t = 1; t >= 0; t--) begin
		@(posedge clk_i);
		cmp1 <= 16'(5 + $urandom % 20);
		cmp0 <= 16'(1 + $urandom % 4);
		wr(4'h2, t ? 8'h25 : 8'h21);
		run(1);
		mx = 0;
		repeat (t ? 60 : 65600) begin
			@(posedge clk_i);
			#1 if (cnt > mx) mx = cnt;
		end
		`CHK("max", t ? cmp1 : 16'hffff, mx)
		run(0);
		rdc(4'h4, t ? 8'h03 : 8'h07);
		rdc(4'h4, 8'h00);
	end
	$display("count and status test done");
	for (s = 0; s < 4; s++) begin
		run(0);
		wr(4'h2, 8'(8'h20 + s));
		run(1);
		if (s == 0) repeat (12) hit(0);
		else repeat (64) @(posedge clk_i);
		e = s == 0 ? 6 : 64 >> (2 * s - 2);
		#1 `CHK("ticks", e, cnt)
	end
	run(0);
	pre <= 0;
	wr(4'h2, 8'h21);
	run(1);
	repeat (16) @(posedge clk_i);
	#1 `CHK("halted", 16'h0000, cnt)
	@(posedge clk_i);
	pre <= 1;
	$display("clock select test done");
	wr(4'h3, 8'h33);
	for (s = 0; s < 4; s++) begin
		wr(4'h2, 8'(8'h21 + 8 * s));
		for (k = 0; k < 8; k++) begin
			hit(k % 4);
			t = tgt(s, k % 4, ins[k % 4]);
			if (t == 0) exp0 = mx;
			if (t == 1) exp1 = mx;
			if (t < 2) ff = !ff;
			`CHK("cap0", exp0, cap0)
			`CHK("cap1", exp1, cap1)
			`CHK("tout", ff, tout)
		end
	end
	wr(4'h2, 8'h01);
	exp0 = mx;
	ff = !ff;
	`CHK("swcap", exp0, cap0)
	`CHK("tout", ff, tout)
	rdc(4'h3, 8'h33);
	$display("capture test done");
	stop_test;
end
endmodule
